// ===== hw/par_arb.v
// Purpose: PCI bus arbiter with retry-limit and target-abort guard
// Assumes: all inputs synchronous to clk_sys
// Notes: outcome strobes come from the PCI initiator engine
`timescale 1ns/1ps
`include "par_arb_regs.vh"
module par_arb (
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Internal initiators
	input wire [`PAR_NUM_INT-1:0] int_req,
	input wire [`PAR_NUM_INT-1:0] int_write,
	input wire [`PAR_NUM_INT-1:0] int_postable,
	output reg [`PAR_NUM_INT-1:0] int_gnt,
	output reg [`PAR_NUM_INT-1:0] int_ack,
	output reg [`PAR_NUM_INT-1:0] int_tea,
	// External masters
	input wire ext_req_n,
	output reg ext_gnt_n,
	// PCI bus observation
	input wire frame_n,
	input wire irdy_n,
	input wire stop_n,
	input wire trdy_n,
	input wire devsel_n,
	input wire xfer_start,
	input wire xfer_done,
	input wire xfer_retry,
	// Retry limits and status
	input wire [`PAR_RETRY_W-1:0] tx_max_retries,
	input wire [`PAR_RETRY_W-1:0] rx_max_retries,
	output reg cpu_irq,
	output reg [`PAR_RETRY_W-1:0] retry_count
);

	// ====================================================
	// State encoding
	localparam ST_NONE = 2'h0;
	localparam ST_INT = 2'h1;
	localparam ST_EXT = 2'h2;

	// ====================================================
	// Registers and next values
	reg [1:0] owner_q;
	reg [1:0] owner_d;
	reg idx_q;
	reg idx_d;
	reg busy_q;
	reg busy_d;
	reg [`PAR_NUM_INT-1:0] gnt_d;
	reg [`PAR_NUM_INT-1:0] ack_d;
	reg [`PAR_NUM_INT-1:0] tea_d;
	reg ext_gnt_n_d;
	reg irq_d;
	reg [`PAR_RETRY_W-1:0] count_d;

	// ====================================================
	// Bus observation
	wire bus_idle = frame_n & irdy_n;
	// Abort only counts while a transfer holds the bus
	wire tgt_abort = ~stop_n & trdy_n & devsel_n & ~bus_idle;

	// ====================================================
	// Retry guard
	wire [`PAR_RETRY_W-1:0] limit = int_write[idx_q] ? tx_max_retries : rx_max_retries;
	wire posted = int_write[idx_q] & int_postable[idx_q];
	wire [`PAR_RETRY_W:0] count_inc = {1'b0, retry_count} + 9'h001;
	// Zero disables the guard; FF gives the widest window
	wire limit_hit = xfer_retry & (count_inc >= {1'b0, limit}) & (limit != 8'h00);

	// ====================================================
	// Helpers
	// Lowest index wins among internal requesters
	function pick;
		input [`PAR_NUM_INT-1:0] r;
		begin
			pick = r[0] ? 1'b0 : 1'b1;
		end
	endfunction

	// One-hot strobe for the owning initiator
	function [`PAR_NUM_INT-1:0] sel_vec;
		input i;
		begin
			sel_vec = i ? 2'h2 : 2'h1;
		end
	endfunction

	// ====================================================
	// Next-state decode
	always @* begin
		owner_d = owner_q;
		idx_d = idx_q;
		busy_d = busy_q;
		gnt_d = int_gnt;
		ack_d = 2'h0;
		tea_d = 2'h0;
		ext_gnt_n_d = ext_gnt_n;
		irq_d = 1'b0;
		count_d = retry_count;
		case (owner_q)
		ST_NONE: begin
			// Stale busy from an internal transfer must not end the next grant
			busy_d = 1'b0;
			// External wins ties, so a same-cycle internal request waits
			if (~ext_req_n) begin
				owner_d = ST_EXT;
				ext_gnt_n_d = 1'b0;
			end else if (|int_req) begin
				owner_d = ST_INT;
				idx_d = pick(int_req);
				gnt_d = sel_vec(pick(int_req));
			end
		end
		ST_EXT: begin
			// No parking: grant dropped once external transfer ends
			if (busy_q & bus_idle) begin
				ext_gnt_n_d = 1'b1;
				owner_d = ST_NONE;
				busy_d = 1'b0;
			end else if (~frame_n) begin
				busy_d = 1'b1;
			end else if (ext_req_n & ~busy_q) begin
				ext_gnt_n_d = 1'b1;
				owner_d = ST_NONE;
			end
		end
		ST_INT: begin
			// Posted writes release the internal bus at start
			if (xfer_start) begin
				count_d = 8'h00;
				busy_d = 1'b1;
				if (posted) begin
					ack_d = sel_vec(idx_q);
				end
			end
			if (xfer_done) begin
				count_d = 8'h00;
				if (~posted) begin
					ack_d = sel_vec(idx_q);
				end
				gnt_d = 2'h0;
				owner_d = ST_NONE;
			end else if (tgt_abort) begin
				count_d = 8'h00;
				irq_d = 1'b1;
				if (~posted) begin
					tea_d = sel_vec(idx_q);
				end
				gnt_d = 2'h0;
				owner_d = ST_NONE;
			end else if (limit_hit) begin
				count_d = 8'h00;
				irq_d = 1'b1;
				if (~posted) begin
					tea_d = sel_vec(idx_q);
				end
				gnt_d = 2'h0;
				owner_d = ST_NONE;
			end else if (xfer_retry) begin
				// Grant kept through retries; only done, limit or abort frees it
				count_d = count_inc[`PAR_RETRY_W-1:0];
			end
		end
		default: begin
			// Unused code: recover to idle with no grant
			owner_d = ST_NONE;
			gnt_d = 2'h0;
			ext_gnt_n_d = 1'b1;
		end
		endcase
	end

	// ====================================================
	// Registers
	// Arbitration state
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			owner_q <= ST_NONE;
			idx_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			owner_q <= owner_d;
			idx_q <= idx_d;
			busy_q <= busy_d;
		end
	end

	// Grants, all off during reset
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			int_gnt <= 2'h0;
			ext_gnt_n <= 1'b1;
		end else begin
			int_gnt <= gnt_d;
			ext_gnt_n <= ext_gnt_n_d;
		end
	end

	// Single-cycle completion and error strobes
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			int_ack <= 2'h0;
			int_tea <= 2'h0;
			cpu_irq <= 1'b0;
		end else begin
			int_ack <= ack_d;
			int_tea <= tea_d;
			cpu_irq <= irq_d;
		end
	end

	// Retry count, visible as status
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			retry_count <= 8'h00;
		end else begin
			retry_count <= count_d;
		end
	end
endmodule

// ===== hw/par_arb_regs.vh
// Purpose: constants for the PCI arbiter with retry guard
// Assumes: one clock, clk_sys at 200 MHz
// Notes: no software-visible registers; limits arrive as ports
// What this block does
// - At most one initiator owns the bus.
// - Late internal request never joins external grant.
// - After retry, keep granting same core.
// - Posted write completes internally at once.
// - Non-posted transfers stay pending during retries.
// - Count retries against programmable maximum per direction.
// - Retry limit raises interrupt, and transfer error if non-posted.
// - Software should program large limit, e.g. FF.
// - Target abort raises interrupt, and transfer error if non-posted.
// - Broken livelock aborts pending non-posted transfer.
`ifndef PAR_ARB_REGS_VH
`define PAR_ARB_REGS_VH
`define PAR_NUM_INT 2
`define PAR_RETRY_W 8
`define PAR_RETRY_RST 8'hFF
`define PAR_OWN_NONE 2'h0
`define PAR_OWN_INT 2'h1
`define PAR_OWN_EXT 2'h2
`endif

// ===== tb/par_arb_asserts.sv
// Purpose: arbiter checks. Assumes: one clock. Notes: bound below
`timescale 1ns/1ps
module par_arb_asserts(
	input wire clk_sys,rst,ext_req_n,ext_gnt_n,stop_n,xfer_start,xfer_retry,cpu_irq,
	input wire [1:0] int_write,int_postable,int_gnt,int_ack,int_tea,
	input wire [7:0] rx_max_retries,retry_count);
default clocking @(posedge clk_sys); endclocking
default disable iff (rst);
one_own_a: assert property($onehot0({int_gnt,~ext_gnt_n}))else $error("owners");
late_int_a: assert property(!ext_req_n&&int_gnt==0&&ext_gnt_n|=>int_gnt==0)else $error("late");
post_ack_a: assert property(int_gnt[0]&&xfer_start&&int_write[0]&&int_postable[0]|=>int_ack[0])else $error("ack");
tea_irq_a: assert property(int_tea!=0|->cpu_irq)else $error("irq");
tea_free_a: assert property(int_tea!=0|->int_gnt==0)else $error("free");
clr_cnt_a: assert property(xfer_start|=>retry_count==0)else $error("clr");
lim_hit_a: assert property(int_gnt[0]&&!int_write[0]&&xfer_retry&&rx_max_retries!=0
	&&retry_count+9'h1>=rx_max_retries|=>int_tea[0])else $error("lim");
keep_cnt_a: assert property(int_gnt!=0&&int_write==0&&xfer_retry&&stop_n&&retry_count+9'h1<rx_max_retries
	|=>int_gnt==$past(int_gnt)&&retry_count==$past(retry_count)+8'h1)else $error("cnt");
cover property(!ext_gnt_n);
cover property(int_tea!=0);
cover property(int_ack!=0);
endmodule
bind par_arb par_arb_asserts u_chk(.*);

// ===== tb/par_ext_model.sv
// Purpose: external master. Assumes: grant low active. Notes: frame three clocks late
`timescale 1ns/1ps
module par_ext_model(input wire clk_sys,rst,go,ext_gnt_n,output reg ext_req_n,frame_n);
reg [2:0] n_q;
always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		ext_req_n<=1'b1;
		frame_n<=1'b1;
		n_q<=3'h0;
	end else begin
		n_q<=ext_gnt_n?3'h0:n_q+3'h1;
		if (go&&ext_gnt_n)
			ext_req_n<=1'b0;
		if (n_q==3'h2) begin
			ext_req_n<=1'b1;
			frame_n<=1'b0;
		end
		if (n_q==3'h4)
			frame_n<=1'b1;
	end
end
endmodule

// ===== tb/test_par_arb.sv
// Purpose: arbiter bench. Assumes: 200 MHz. Notes: random limits
`timescale 1ns/1ps
module test_par_arb;
reg clk_sys=0,rst=1,go=0,st=0,dn=0,rt=0,stp=1,ib=1;
reg [1:0] rq=0,wr=0,po=0,gs;
reg [7:0] lim=0;
wire [1:0] g,ack,tea;
wire gn,rn,fn,irq;
wire [7:0] cnt;
integer bad_count=0,comparisons=0,cy=0,i,j,k;
always #2.5 clk_sys=~clk_sys;
par_ext_model pm(.clk_sys(clk_sys),.rst(rst),.go(go),.ext_gnt_n(gn),.ext_req_n(rn),.frame_n(fn));
par_arb dut(.clk_sys(clk_sys),.rst(rst),.int_req(rq),.int_write(wr),.int_postable(po),.int_gnt(g),
	.int_ack(ack),.int_tea(tea),.ext_req_n(rn),.ext_gnt_n(gn),.frame_n(fn&ib),.irdy_n(ib),.stop_n(stp),
	.trdy_n(1'b1),.devsel_n(1'b1),.xfer_start(st),.xfer_done(dn),.xfer_retry(rt),.tx_max_retries(lim),
	.rx_max_retries(lim),.cpu_irq(irq),.retry_count(cnt));
task chk(input [23:0] nm,input [7:0] s,e);
	begin
		comparisons=comparisons+1;
		if (s!==e) begin
			bad_count=bad_count+1;
			$display("[FAIL] %s exp %h saw %h",nm,e,s);
		end
	end
endtask
task test_done;
	begin
		$display("checks %0d fails %0d",comparisons,bad_count);
		if (bad_count==0&&comparisons>0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
endtask
always @(posedge clk_sys) begin
	cy<=cy+1;
	if (cy==5000) begin
		bad_count=bad_count+1;
		test_done;
	end
end
function [1:0] win(input [1:0] r);
	win=r[0]?2'h1:{r[1],1'b0};
endfunction
task xfer(input ab);
	begin
		@(posedge clk_sys);
		rq<=2'($urandom%3+1);
		wr<=2'($urandom);
		po<=2'($urandom);
		lim<=8'($urandom%4+1);
		ib<=1'b0;
		for (k=0;k<9&&g===2'h0;k++) @(posedge clk_sys);
		#1 chk("gnt",g,win(rq));
		gs=g;
		@(posedge clk_sys) rq<=2'h0;
		st<=1'b1;
		@(posedge clk_sys) st<=1'b0;
		#1 if ((wr&po&gs)!=0) begin
			chk("ack",ack,gs);
			@(posedge clk_sys) dn<=1'b1;
			@(posedge clk_sys) dn<=1'b0;
		end else for (j=1;j<=lim;j++) begin
			@(posedge clk_sys) if (ab) stp<=1'b0; else rt<=1'b1;
			@(posedge clk_sys) rt<=1'b0;
			stp<=1'b1;
			#1 if (ab||j==lim) begin
				chk("tea",tea,gs);
				chk("irq",irq,1);
				j=9;
			end else chk("cnt",cnt,j);
		end
		@(posedge clk_sys) ib<=1'b1;
	end
endtask
initial begin
	k=$urandom(32'h21692dc4);
	repeat (12) @(posedge clk_sys);
	rst<=1'b0;
	@(posedge clk_sys) go<=1'b1;
	@(posedge clk_sys) rq<=2'h1;
	for (k=0;k<9&&gn!==1'b0;k++) @(posedge clk_sys);
	#1 chk("ext",gn,0);
	chk("int",g,0);
	@(posedge clk_sys) go<=1'b0;
	rq<=2'h0;
	for (k=0;k<20&&gn!==1'b1;k++) @(posedge clk_sys);
	for (i=0;i<40;i++) xfer(i%3==2);
	test_done;
end
endmodule
